// File: logic/mpc_defines.vh
`ifndef MPC_DEFINES_VH
`define MPC_DEFINES_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define MPC_OFF_PORT_CTL 8'hd0
`define MPC_OFF_PHY_CTL0 8'he0
`define MPC_OFF_RETRAIN0 8'he4
`define MPC_OFF_PHY_CTL1 8'hf0
`define MPC_OFF_RETRAIN1 8'hf4
// ****************************************
// mirror port control fields
// ****************************************
`define MPC_PC_TX_EN 0
`define MPC_PC_RX_EN 1
`define MPC_PC_TX_SEL 2
`define MPC_PC_RX_SEL 3
`define MPC_PC_SQUASH 4
`define MPC_PC_DIRECT_L0 5
`define MPC_PC_SYNC_OFF 6
`define MPC_PC_SPARE 7
`define MPC_PC_MASK 32'h0000_00ff
`define MPC_PC_RESET 32'h0000_0003
// ****************************************
// physical control fields
// ****************************************
`define MPC_PH_RESET_BIT 0
`define MPC_PH_UPGRADE 1
`define MPC_PH_CAL_BYPASS 2
`define MPC_PH_LAT_FIX 3
`define MPC_PH_SINGLE_STEP 4
`define MPC_PH_INIT_BEGIN 5
`define MPC_PH_SPEED 7
`define MPC_PH_MODE_LO 8
`define MPC_PH_FREEZE 12
`define MPC_PH_COMP_BLOCK 13
`define MPC_PH_DETERMINISM 14
`define MPC_PH_SCRAMBLE 22
`define MPC_PH_PATTERN 23
`define MPC_PH_LOAD_OFF 27
`define MPC_PH_MASK 32'h08c0_77be
`define MPC_PH_RESET 32'h0000_6020
// ****************************************
// retraining timing fields
// ****************************************
`define MPC_RT_SPACING_LO 0
`define MPC_RT_EXP_LO 10
`define MPC_RT_PKT_LO 16
`define MPC_RT_MASK 32'h003f_3cff
`define MPC_RT_RESET 32'h001d_2c03
`endif

// File: logic/mpc_regs.v
// Summary of operation
// - tx enable bit, resets to one
// - rx enable bit, resets to one
// - tx port select: zero port0, one port1
// - rx port select: zero port0, one port1
// - squash bit substitutes crc error packets
// - direct-to-active skips to L0 from flit lock
// - sync-off bit disables enhanced rx sync
// - load-off bit stops effective value loading
// - pattern bit sends lfsr training pattern
// - scramble bit scrambles tx data
// - determinism bit, resets to one
// - compliance block bit, resets to one
// - freeze bit halts fsm on abort
// - three-bit init mode, zero is normal
// - speed bit selects slow or full
// - init begin bit, resets to one
// - latency fix bit requests remote fix
// - bypass bit skips calibration
// - upgrade bit makes soft reset full
// - reset bit write-one-set, survives lock
// - eight-bit spacing, reset three, zero disables
// - four-bit exponent, reset eleven
`timescale 1ns/100ps
`include "mpc_defines.vh"
module mpc_regs (
	input wire sys_clk,
	input wire rst_b,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	output reg [31:0] cfg_rdata,
	output reg cfg_rvalid,
	input wire [1:0] fast_l0,
	input wire [1:0] physical_layer_reset_done,
	output reg tx_enable,
	output reg rx_enable,
	output reg tx_port_sel,
	output reg rx_port_sel,
	output reg crc_error_substitute,
	output reg direct_to_l0,
	output reg enhanced_sync_off,
	output reg [1:0] effective_value_load_off,
	output reg [1:0] training_pattern_on,
	output reg [1:0] scrambler_on,
	output reg [1:0] determinism_mode,
	output reg [1:0] auto_compliance_block,
	output reg [1:0] freeze_on_abort,
	output reg [5:0] init_mode,
	output reg [1:0] full_speed,
	output reg [1:0] init_begin,
	output reg [1:0] single_step,
	output reg [1:0] latency_fix_request,
	output reg [1:0] calibration_bypass,
	output reg [1:0] soft_reset_upgrade,
	output reg [1:0] physical_layer_reset,
	output reg [15:0] retrain_spacing,
	output reg [7:0] retrain_spacing_exponent,
	output reg [11:0] retrain_packet_count,
	output reg [1:0] regs_locked
);
// ****************************************
// storage and sync of phy status
// ****************************************
reg [31:0] port_ctl;
reg [31:0] phy_ctl [0:1];
reg [31:0] retrain [0:1];
reg [1:0] fast_meta;
reg [1:0] fast_sync;
reg [1:0] done_meta;
reg [1:0] done_sync;
reg [1:0] lock;
reg [31:0] next_rdata;
// mask applied on the full word, before dropping bit 0, so field positions stay aligned
wire [31:0] phy_wmask = cfg_wdata & `MPC_PH_MASK;
integer i;
integer k;

always @(posedge sys_clk) begin
	if (!rst_b) begin
		fast_meta <= 2'h0;
		fast_sync <= 2'h0;
		done_meta <= 2'h0;
		done_sync <= 2'h0;
	end else begin
		fast_meta <= fast_l0;
		fast_sync <= fast_meta;
		done_meta <= physical_layer_reset_done;
		done_sync <= done_meta;
	end
end

// ****************************************
// register writes
// ****************************************
// lock is sticky until reset: once the link reached fast L0 it must not be re-steered
always @(posedge sys_clk) begin
	if (!rst_b) begin
		port_ctl <= `MPC_PC_RESET;
		lock <= 2'h0;
		for (i = 0; i < 2; i = i + 1) begin
			phy_ctl[i] <= `MPC_PH_RESET;
			retrain[i] <= `MPC_RT_RESET;
		end
	end else begin
		if (cfg_wr && cfg_addr == `MPC_OFF_PORT_CTL)
			port_ctl <= cfg_wdata & `MPC_PC_MASK;
		for (i = 0; i < 2; i = i + 1) begin
			lock[i] <= lock[i] | fast_sync[i];
			// each copy decodes only its own offsets
			if (cfg_wr && cfg_addr == (i == 0 ? `MPC_OFF_PHY_CTL0 : `MPC_OFF_PHY_CTL1)) begin
				if (!lock[i])
					phy_ctl[i][31:1] <= phy_wmask[31:1];
				// write-one-to-set; set wins over the completion clear
				if (cfg_wdata[`MPC_PH_RESET_BIT])
					phy_ctl[i][`MPC_PH_RESET_BIT] <= 1'b1;
				else if (done_sync[i])
					phy_ctl[i][`MPC_PH_RESET_BIT] <= 1'b0;
			end else if (done_sync[i]) begin
				phy_ctl[i][`MPC_PH_RESET_BIT] <= 1'b0;
			end
			if (cfg_wr && cfg_addr == (i == 0 ? `MPC_OFF_RETRAIN0 : `MPC_OFF_RETRAIN1))
				retrain[i] <= cfg_wdata & `MPC_RT_MASK;
		end
	end
end

// ****************************************
// register reads
// ****************************************
always @* begin
	case (cfg_addr)
	`MPC_OFF_PORT_CTL: next_rdata = port_ctl;
	`MPC_OFF_PHY_CTL0: next_rdata = phy_ctl[0];
	`MPC_OFF_RETRAIN0: next_rdata = retrain[0];
	`MPC_OFF_PHY_CTL1: next_rdata = phy_ctl[1];
	`MPC_OFF_RETRAIN1: next_rdata = retrain[1];
	default: next_rdata = 32'h0000_0000;
	endcase
end

always @(posedge sys_clk) begin
	if (!rst_b) begin
		cfg_rdata <= 32'h0000_0000;
		cfg_rvalid <= 1'b0;
	end else begin
		cfg_rvalid <= cfg_rd;
		cfg_rdata <= cfg_rd ? next_rdata : 32'h0000_0000;
	end
end

// ****************************************
// control outputs, registered copies
// ****************************************
always @(posedge sys_clk) begin
	if (!rst_b) begin
		tx_enable <= 1'b1;
		rx_enable <= 1'b1;
		tx_port_sel <= 1'b0;
		rx_port_sel <= 1'b0;
		crc_error_substitute <= 1'b0;
		direct_to_l0 <= 1'b0;
		enhanced_sync_off <= 1'b0;
		effective_value_load_off <= 2'h0;
		training_pattern_on <= 2'h0;
		scrambler_on <= 2'h0;
		determinism_mode <= 2'h3;
		auto_compliance_block <= 2'h3;
		freeze_on_abort <= 2'h0;
		init_mode <= 6'h00;
		full_speed <= 2'h0;
		init_begin <= 2'h3;
		single_step <= 2'h0;
		latency_fix_request <= 2'h0;
		calibration_bypass <= 2'h0;
		soft_reset_upgrade <= 2'h0;
		physical_layer_reset <= 2'h0;
		retrain_spacing <= 16'h0303;
		retrain_spacing_exponent <= 8'hbb;
		retrain_packet_count <= 12'h75d;
		regs_locked <= 2'h0;
	end else begin
		tx_enable <= port_ctl[`MPC_PC_TX_EN];
		rx_enable <= port_ctl[`MPC_PC_RX_EN];
		tx_port_sel <= port_ctl[`MPC_PC_TX_SEL];
		rx_port_sel <= port_ctl[`MPC_PC_RX_SEL];
		crc_error_substitute <= port_ctl[`MPC_PC_SQUASH];
		direct_to_l0 <= port_ctl[`MPC_PC_DIRECT_L0];
		enhanced_sync_off <= port_ctl[`MPC_PC_SYNC_OFF];
		regs_locked <= lock;
		for (k = 0; k < 2; k = k + 1) begin
			effective_value_load_off[k] <= phy_ctl[k][`MPC_PH_LOAD_OFF];
			training_pattern_on[k] <= phy_ctl[k][`MPC_PH_PATTERN];
			scrambler_on[k] <= phy_ctl[k][`MPC_PH_SCRAMBLE];
			determinism_mode[k] <= phy_ctl[k][`MPC_PH_DETERMINISM];
			auto_compliance_block[k] <= phy_ctl[k][`MPC_PH_COMP_BLOCK];
			freeze_on_abort[k] <= phy_ctl[k][`MPC_PH_FREEZE];
			init_mode[k*3 +: 3] <= phy_ctl[k][`MPC_PH_MODE_LO +: 3];
			full_speed[k] <= phy_ctl[k][`MPC_PH_SPEED];
			init_begin[k] <= phy_ctl[k][`MPC_PH_INIT_BEGIN];
			single_step[k] <= phy_ctl[k][`MPC_PH_SINGLE_STEP];
			latency_fix_request[k] <= phy_ctl[k][`MPC_PH_LAT_FIX];
			calibration_bypass[k] <= phy_ctl[k][`MPC_PH_CAL_BYPASS];
			soft_reset_upgrade[k] <= phy_ctl[k][`MPC_PH_UPGRADE];
			physical_layer_reset[k] <= phy_ctl[k][`MPC_PH_RESET_BIT];
			// zero spacing means retraining disabled; the phy reads zero as off
			retrain_spacing[k*8 +: 8] <= retrain[k][`MPC_RT_SPACING_LO +: 8];
			retrain_spacing_exponent[k*4 +: 4] <= retrain[k][`MPC_RT_EXP_LO +: 4];
			retrain_packet_count[k*6 +: 6] <= retrain[k][`MPC_RT_PKT_LO +: 6];
		end
	end
end
endmodule // mpc_regs

// File: tb/mpc_phy_model.sv
`timescale 1ns/100ps
// ************
// far side phy
// ************
module mpc_phy_model (
	input wire sys_clk,
	input wire [1:0] reset_cmd,
	input wire [1:0] reach_l0,
	output reg [1:0] fast_l0 = 2'h0,
	output reg [1:0] physical_layer_reset_done = 2'h0
);
	// reset takes two cycles, so the bit is seen set before it clears
	reg [1:0] busy = 2'h0;
	always @(posedge sys_clk) begin
		busy <= reset_cmd;
		physical_layer_reset_done <= busy & reset_cmd;
		fast_l0 <= reach_l0;
	end
endmodule // mpc_phy_model

// File: tb/mpc_regs_properties.sv
`timescale 1ns/100ps
// ****************
// register checker
// ****************
module mpc_regs_properties (
	input wire sys_clk,
	input wire rst_b,
	input wire cfg_wr,
	input wire cfg_rd,
	input wire [7:0] cfg_addr,
	input wire [31:0] cfg_wdata,
	input wire cfg_rvalid,
	input wire tx_enable,
	input wire rx_enable,
	input wire tx_port_sel,
	input wire rx_port_sel,
	input wire crc_error_substitute,
	input wire direct_to_l0,
	input wire enhanced_sync_off,
	input wire [1:0] training_pattern_on,
	input wire [1:0] scrambler_on,
	input wire [5:0] init_mode,
	input wire [1:0] full_speed,
	input wire [1:0] physical_layer_reset,
	input wire [15:0] retrain_spacing,
	input wire [7:0] retrain_spacing_exponent,
	input wire [1:0] regs_locked
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	wire w_pc = cfg_wr && cfg_addr == 8'hd0;
	wire w_p0 = cfg_wr && cfg_addr == 8'he0;
	wire w_p1 = cfg_wr && cfg_addr == 8'hf0 && !regs_locked[1];
	wire w_rt = cfg_wr && cfg_addr == 8'he4;
	a_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no answer");
	a_rvalid_cause: assert property (cfg_rvalid |-> $past(cfg_rd)) else $error("stray rvalid");
	a_port_follow: assert property (w_pc |-> ##2 {enhanced_sync_off, direct_to_l0,
		crc_error_substitute, rx_port_sel, tx_port_sel, rx_enable, tx_enable}
		== $past(cfg_wdata[6:0], 2)) else $error("port ctl");
	a_reset_set: assert property (w_p0 && cfg_wdata[0] |-> ##2 physical_layer_reset[0])
		else $error("reset bit");
	a_lock_hold: assert property (w_p0 && regs_locked[0] |-> ##2
		$stable({full_speed[0], init_mode[2:0]})) else $error("lock");
	a_open_follow: assert property (w_p0 && !regs_locked[0] |-> ##2
		{full_speed[0], init_mode[2:0]} == $past({cfg_wdata[7], cfg_wdata[10:8]}, 2))
		else $error("phy ctl");
	a_retrain_follow: assert property (w_rt |-> ##2
		{retrain_spacing_exponent[3:0], retrain_spacing[7:0]}
		== $past({cfg_wdata[13:10], cfg_wdata[7:0]}, 2)) else $error("retrain");
	a_inst1_follow: assert property (w_p1 |-> ##2
		{training_pattern_on[1], scrambler_on[1]} == $past(cfg_wdata[23:22], 2))
		else $error("inst1");
	cover property (w_p0 && regs_locked[0]);
	cover property (cfg_rvalid);
	cover property (w_p1);
endmodule // mpc_regs_properties
bind mpc_regs mpc_regs_properties u_mpc_regs_properties (.*);

// File: tb/tb_mpc_regs.sv
`timescale 1ns/100ps
// ******************
// register bank bench
// ******************
module tb_mpc_regs;
	reg sys_clk, rst_b, cfg_wr, cfg_rd;
	reg [7:0] cfg_addr;
	reg [31:0] cfg_wdata;
	reg [1:0] reach_l0;
	wire [31:0] cfg_rdata;
	wire cfg_rvalid, tx_enable, rx_enable, tx_port_sel, rx_port_sel;
	wire crc_error_substitute, direct_to_l0, enhanced_sync_off;
	wire [1:0] fast_l0, physical_layer_reset_done, effective_value_load_off, training_pattern_on;
	wire [1:0] scrambler_on, determinism_mode, auto_compliance_block, freeze_on_abort;
	wire [1:0] full_speed, init_begin, single_step, latency_fix_request, calibration_bypass;
	wire [1:0] soft_reset_upgrade, physical_layer_reset, regs_locked;
	wire [5:0] init_mode;
	wire [15:0] retrain_spacing;
	wire [7:0] retrain_spacing_exponent;
	wire [11:0] retrain_packet_count;
	integer bad_count = 0, num_checks = 0, i;
	mpc_regs u_mpc_regs (.*);
	mpc_phy_model u_mpc_phy_model (.sys_clk, .reset_cmd(physical_layer_reset), .reach_l0,
		.fast_l0, .physical_layer_reset_done);
	task chk(input [31:0] got, input [31:0] exp);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				bad_count = bad_count + 1;
				$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [31:0] d);
		begin
			@(posedge sys_clk);
			cfg_wr <= 1'h1;
			cfg_addr <= a;
			cfg_wdata <= d;
			@(posedge sys_clk);
			cfg_wr <= 1'h0;
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			@(posedge sys_clk);
			cfg_rd <= 1'h1;
			cfg_addr <= a;
			@(posedge sys_clk);
			cfg_rd <= 1'h0;
			#1;
			chk({31'h0, cfg_rvalid}, 32'h1);
			chk(cfg_rdata, e);
		end
	endtask
	// outputs lag a write by two edges, and wr has already spent the first; two spare edges for margin
	task settle;
		begin
			repeat (3) @(posedge sys_clk);
			#1;
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", num_checks, bad_count);
			if (bad_count == 0 && num_checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		repeat (5000) @(posedge sys_clk);
		bad_count = bad_count + 1;
		summarize;
	end
	initial begin
		{rst_b, cfg_wr, cfg_rd, cfg_addr, cfg_wdata, reach_l0} = 0;
		repeat (16) @(posedge sys_clk);
		rst_b <= 1'h1;
		rd(8'hd0, 32'h3);
		rd(8'he0, 32'h6020);
		rd(8'hf4, 32'h001d_2c03);
		rd(8'h00, 32'h0);
		$display("reset test done");
		for (i = 0; i < 8; i = i + 1) begin
			wr(8'hd0, 32'h1 << i);
			settle;
			chk({25'h0, enhanced_sync_off, direct_to_l0, crc_error_substitute, rx_port_sel,
				tx_port_sel, rx_enable, tx_enable}, (32'h1 << i) & 32'h7f);
			rd(8'hd0, 32'h1 << i);
		end
		$display("port test done");
		wr(8'he0, 32'h08c0_77be);
		wr(8'hf0, 32'h0);
		settle;
		chk({16'h0, effective_value_load_off, training_pattern_on, scrambler_on, determinism_mode,
			auto_compliance_block, freeze_on_abort, full_speed, init_begin}, 32'h5555);
		chk({18'h0, single_step, latency_fix_request, calibration_bypass, soft_reset_upgrade,
			init_mode}, 32'h1547);
		rd(8'he0, 32'h08c0_77be);
		rd(8'hf0, 32'h0);
		wr(8'he0, 32'h1);
		settle;
		chk({30'h0, physical_layer_reset}, 32'h1);
		repeat (12) @(posedge sys_clk);
		rd(8'he0, 32'h0);
		$display("phy test done");
		wr(8'he4, 32'hffff_ffff);
		rd(8'he4, 32'h003f_3cff);
		wr(8'he4, 32'h0);
		settle;
		chk({8'h0, retrain_spacing_exponent, retrain_spacing}, 32'hb0_0300);
		chk({20'h0, retrain_packet_count}, 32'h740);
		rd(8'hf4, 32'h001d_2c03);
		$display("retrain test done");
		wr(8'he0, 32'h80);
		reach_l0 <= 2'h1;
		repeat (6) @(posedge sys_clk);
		#1;
		chk({30'h0, regs_locked}, 32'h1);
		wr(8'he0, 32'hffff_ffff);
		settle;
		chk({30'h0, physical_layer_reset}, 32'h1);
		repeat (12) @(posedge sys_clk);
		rd(8'he0, 32'h80);
		wr(8'hf0, 32'h20);
		rd(8'hf0, 32'h20);
		$display("lock test done");
		summarize;
	end
endmodule // tb_mpc_regs
